// >>> tpwm_defines.vh
// Constants for the 8-bit waveform timer: register offsets, field positions,
// reset values and mode codes. Assumes inclusion by bare name.
`ifndef TPWM_DEFINES_VH
`define TPWM_DEFINES_VH

// Register byte offsets on the APB
`define TPWM_ADDR_CTRL 8'h00
`define TPWM_ADDR_COUNT 8'h04
`define TPWM_ADDR_CMPA 8'h08
`define TPWM_ADDR_CMPB 8'h0c
`define TPWM_ADDR_STATUS 8'h10

// Control register fields
`define TPWM_MODE_LSB 0
`define TPWM_MODE_MSB 2
`define TPWM_ACTB_LSB 4
`define TPWM_ACTB_MSB 5
`define TPWM_ACTA_LSB 6
`define TPWM_ACTA_MSB 7
`define TPWM_PRESC_LSB 8
`define TPWM_PRESC_MSB 10
`define TPWM_CTRL_RESET 11'h000

// Status register bits
`define TPWM_ST_WRAP 0
`define TPWM_ST_MATCH_A 1
`define TPWM_ST_MATCH_B 2
`define TPWM_ST_DIR_UP 3

// Wave mode select codes
`define TPWM_MODE_NORMAL 3'h0
`define TPWM_MODE_PC_FF 3'h1
`define TPWM_MODE_CTC 3'h2
`define TPWM_MODE_FAST_FF 3'h3
`define TPWM_MODE_PC_CMP 3'h5
`define TPWM_MODE_FAST_CMP 3'h7

// Output action codes
`define TPWM_ACT_NONE 2'h0
`define TPWM_ACT_TOGGLE 2'h1
`define TPWM_ACT_CLEAR 2'h2
`define TPWM_ACT_SET 2'h3

// Prescale select codes
`define TPWM_PRE_STOP 3'h0
`define TPWM_PRE_1 3'h1
`define TPWM_PRE_8 3'h2
`define TPWM_PRE_64 3'h3
`define TPWM_PRE_256 3'h4
`define TPWM_PRE_1024 3'h5

// Counter extremes
`define TPWM_BOTTOM 8'h00
`define TPWM_MAX 8'hff

`endif

// >>> tpwm_top.v
// 8-bit timer with clear-on-match, fast PWM and phase-correct PWM modes,
// two compare channels and an APB register slave.
// Assumes one clock, an APB master on that clock, and port logic outside.
//
// Our own choices: the register addresses and the APB register port.

`include "tpwm_defines.vh"

module tpwm_top (
  // Clock and reset
  input wire core_clk_in,
  input wire rstn_in,
  // APB slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg pready_out,
  output reg [31:0] prdata_out,
  output reg pslverr_out,
  // Wave outputs towards the port pins
  output wire wave_out_a_out,
  output wire wave_out_b_out
);

  reg [10:0] ctrl_r;
  reg [7:0] count_r;
  reg [7:0] count_nxt;
  reg dir_up_r;
  reg dir_up_nxt;
  reg block_r;
  reg [9:0] pre_cnt_r;
  reg tick_r;
  reg tick_nxt;
  reg [2:0] flags_r;
  // Per channel views, each driven from its own generate slice
  wire [7:0] cmp_buf_r [0:1];
  wire [7:0] cmp_act_r [0:1];
  wire [1:0] wave_r;
  reg [31:0] rdata_nxt;
  reg unmapped_nxt;

  wire [2:0] wave_mode_select = ctrl_r[`TPWM_MODE_MSB:`TPWM_MODE_LSB];
  wire wave_mode_high_bit = wave_mode_select[2];
  wire [1:0] out_action_a = ctrl_r[`TPWM_ACTA_MSB:`TPWM_ACTA_LSB];
  wire [1:0] out_action_b = ctrl_r[`TPWM_ACTB_MSB:`TPWM_ACTB_LSB];
  wire [2:0] presc_sel = ctrl_r[`TPWM_PRESC_MSB:`TPWM_PRESC_LSB];

  // Mode decode
  // Modes 0, 4 and 6 fall through to a plain up count with non-PWM actions.
  // Top follows compare A only with the high mode bit set, so modes 1 and 3
  // always run the full 8-bit range whatever compare A holds.
  wire is_ctc = (wave_mode_select == `TPWM_MODE_CTC);
  wire is_fast = (wave_mode_select == `TPWM_MODE_FAST_FF) || (wave_mode_select == `TPWM_MODE_FAST_CMP);
  wire is_pc = (wave_mode_select == `TPWM_MODE_PC_FF) || (wave_mode_select == `TPWM_MODE_PC_CMP);
  wire is_pwm = is_fast | is_pc;
  wire [7:0] top_val = wave_mode_high_bit ? cmp_act_r[0] : `TPWM_MAX;
  wire at_top = (count_r == top_val);
  wire at_bottom = (count_r == `TPWM_BOTTOM);

  // APB commit happens only at the edge where the master sees pready
  // Writes take effect at that edge and no other, so a stalled master
  // never causes a register to be written twice.
  wire bus_commit = psel_in & penable_in & pready_out;
  wire wr_commit = bus_commit & pwrite_in;
  wire wr_ctrl = wr_commit & (paddr_in == `TPWM_ADDR_CTRL);
  wire wr_count = wr_commit & (paddr_in == `TPWM_ADDR_COUNT);
  wire wr_status = wr_commit & (paddr_in == `TPWM_ADDR_STATUS);
  wire [1:0] wr_cmp;
  assign wr_cmp[0] = wr_commit & (paddr_in == `TPWM_ADDR_CMPA);
  assign wr_cmp[1] = wr_commit & (paddr_in == `TPWM_ADDR_CMPB);

  // Buffered compare values load at top: fast PWM wraps there, phase-correct turns there
  wire load_buf = tick_r & at_top & (is_fast | (is_pc & dir_up_r));

  // Matches, suppressed for the first timer cycle after a counter write
  // Without the block, loading the counter with the compare value would fire
  // a match and a flag straight away, before the timer has moved at all.
  wire [1:0] match;
  assign match[0] = tick_r & ~block_r & (count_r == cmp_act_r[0]);
  assign match[1] = tick_r & ~block_r & (count_r == cmp_act_r[1]);

  // Wrap event per mode
  wire wrap_set = tick_r & (is_fast ? at_top :
                            is_pc ? (at_bottom & ~dir_up_r) :
                            (count_r == `TPWM_MAX));

  // Free running prescale divider
  // Never cleared on a prescale change: the first tick after a new setting
  // may come early, by up to one clock less than a full division period.
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pre_cnt_r <= 10'h000;
    end else begin
      pre_cnt_r <= pre_cnt_r + 10'h001;
    end
  end

  // Timer tick select
  always @* begin
    case (presc_sel)
      `TPWM_PRE_1: tick_nxt = 1'b1;
      `TPWM_PRE_8: tick_nxt = &pre_cnt_r[2:0];
      `TPWM_PRE_64: tick_nxt = &pre_cnt_r[5:0];
      `TPWM_PRE_256: tick_nxt = &pre_cnt_r[7:0];
      `TPWM_PRE_1024: tick_nxt = &pre_cnt_r[9:0];
      default: tick_nxt = 1'b0;
    endcase
  end

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= tick_nxt;
    end
  end

  // Counting sequence per mode
  // Phase-correct holds neither top nor bottom for an extra tick: the turn at top
  // steps straight down, the turn at bottom steps straight up.
  // A count written above compare A in mode 2 runs on through 0xff first.
  always @* begin
    count_nxt = count_r + 8'h01;
    dir_up_nxt = 1'b1;
    if (is_ctc) begin
      if (count_r == cmp_act_r[0]) begin
        count_nxt = `TPWM_BOTTOM;
      end
    end else if (is_fast) begin
      if (at_top) begin
        count_nxt = `TPWM_BOTTOM;
      end
    end else if (is_pc) begin
      dir_up_nxt = dir_up_r;
      if (dir_up_r) begin
        if (at_top) begin
          count_nxt = count_r - 8'h01;
          dir_up_nxt = 1'b0;
        end
      end else if (at_bottom) begin
        dir_up_nxt = 1'b1;
      end else begin
        count_nxt = count_r - 8'h01;
      end
    end
  end

  // Counter, direction and match blocking
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_r <= `TPWM_BOTTOM;
      dir_up_r <= 1'b1;
      block_r <= 1'b0;
    end else if (wr_count) begin
      count_r <= pwdata_in[7:0];
      block_r <= 1'b1;
    end else if (tick_r) begin
      count_r <= count_nxt;
      dir_up_r <= dir_up_nxt;
      block_r <= 1'b0;
    end
  end

  // Control register
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_r <= `TPWM_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= pwdata_in[10:0];
    end
  end

  // Sticky flags: set wins over write-one-to-clear
  // An event landing on the clearing write is kept, so no tick is lost.
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flags_r <= 3'h0;
    end else begin
      flags_r <= {match[1], match[0], wrap_set} | (flags_r & ~({3{wr_status}} & pwdata_in[2:0]));
    end
  end

  // Per channel compare buffers and wave output
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      wire [1:0] act = (ch == 0) ? out_action_a : out_action_b;
      wire tog_ok = (ch == 0) & wave_mode_high_bit;
      wire up_phase = (dir_up_r & ~at_top) | at_bottom;
      // Bottom reached on the way down: the symmetry point
      wire turn_bottom = at_bottom & ~dir_up_r;
      reg [7:0] buf_r;
      reg [7:0] buf_nxt;
      reg [7:0] act_r;
      reg [7:0] act_nxt;
      reg wave_q_r;
      reg wave_nxt;

      // Export to the shared per channel views
      assign cmp_buf_r[ch] = buf_r;
      assign cmp_act_r[ch] = act_r;
      assign wave_r[ch] = wave_q_r;

      // Compare storage: direct in non-PWM modes, buffered in PWM modes
      // Software always sees the buffer, so a read returns what was written
      always @* begin
        buf_nxt = buf_r;
        act_nxt = act_r;
        if (wr_cmp[ch]) begin
          buf_nxt = pwdata_in[7:0];
        end
        if (wr_cmp[ch] & ~is_pwm) begin
          act_nxt = pwdata_in[7:0];
        end else if (load_buf) begin
          act_nxt = buf_r;
        end
      end

      // Compare registers
      always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          buf_r <= 8'h00;
          act_r <= 8'h00;
        end else begin
          buf_r <= buf_nxt;
          act_r <= act_nxt;
        end
      end

      // Wave generator: next level per mode, held when no event
      // Top beats a match for clear and set in fast PWM, so compare at top gives a flat level.
      always @* begin
        wave_nxt = wave_q_r;
        if (tick_r) begin
          if (is_fast) begin
            if (act[1]) begin
              if (at_top) begin
                wave_nxt = ~act[0];
              end else if (match[ch]) begin
                wave_nxt = act[0];
              end
            end else if (act[0] & tog_ok & match[ch]) begin
              wave_nxt = ~wave_q_r;
            end
          end else if (is_pc) begin
            if (act[1]) begin
              if (match[ch]) begin
                wave_nxt = up_phase ? act[0] : ~act[0];
              end else if (turn_bottom) begin
                wave_nxt = ~act[0];
              end
            end else if (act[0] & tog_ok & match[ch]) begin
              wave_nxt = ~wave_q_r;
            end
          end else if (match[ch]) begin
            case (act)
              `TPWM_ACT_TOGGLE: wave_nxt = ~wave_q_r;
              `TPWM_ACT_CLEAR: wave_nxt = 1'b0;
              `TPWM_ACT_SET: wave_nxt = 1'b1;
              default: wave_nxt = wave_q_r;
            endcase
          end
        end
      end

      // Wave level register, low out of reset
      always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          wave_q_r <= 1'b0;
        end else begin
          wave_q_r <= wave_nxt;
        end
      end
    end
  endgenerate

  assign wave_out_a_out = wave_r[0];
  assign wave_out_b_out = wave_r[1];

  // Read mux
  always @* begin
    rdata_nxt = 32'h0000_0000;
    unmapped_nxt = 1'b0;
    case (paddr_in)
      `TPWM_ADDR_CTRL: rdata_nxt = {21'h000000, ctrl_r};
      `TPWM_ADDR_COUNT: rdata_nxt = {24'h000000, count_r};
      `TPWM_ADDR_CMPA: rdata_nxt = {24'h000000, cmp_buf_r[0]};
      `TPWM_ADDR_CMPB: rdata_nxt = {24'h000000, cmp_buf_r[1]};
      `TPWM_ADDR_STATUS: rdata_nxt = {28'h0000000, dir_up_r, flags_r};
      default: unmapped_nxt = 1'b1;
    endcase
  end

  // APB answer: one wait state, pready high in the second access cycle
  // Read data is latched at the same edge that raises pready, so it stands settled
  // at the edge where the master samples it, and holds until the next read.
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out & unmapped_nxt;
      if (psel_in & penable_in & ~pready_out & ~pwrite_in) begin
        prdata_out <= rdata_nxt;
      end
    end
  end

endmodule

// >>> tpwm_props.sv
// Port checker for the waveform timer.
// Assumes a bind onto tpwm_top.
module tpwm_props (
  // Clock and reset
  input wire core_clk_in,
  input wire rstn_in,
  // APB
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire pready_out,
  input wire [31:0] prdata_out,
  input wire pslverr_out,
  // Waves
  input wire wave_out_a_out,
  input wire wave_out_b_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  reg [10:0] ctrl_r;
  wire bad = (paddr_in[1:0] != 2'h0) || (paddr_in > 8'h10);
  wire halt = (ctrl_r[10:8] == 3'h0) || (ctrl_r[10:8] > 3'h5);
  // Shadow of the control word, taken at the write edge
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in)
      ctrl_r <= 11'h0;
    else if (pready_out && pwrite_in && paddr_in == 8'h0)
      ctrl_r <= pwdata_in[10:0];
  end
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_halt;
    halt ##1 halt ##1 halt;
  endsequence
  AST_RDY_WAIT: assert property (s_setup |-> ##1 !pready_out ##1 pready_out)
    else $error("ready not two cycles after setup");
  AST_RDY_PULSE: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  AST_ERR_RDY: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  AST_UNMAPPED: assert property (s_setup |-> ##2 (pslverr_out == $past(bad, 2)))
    else $error("error flag wrong for address");
  AST_RD_HOLD: assert property (!(pready_out && !pwrite_in) |-> $stable(prdata_out))
    else $error("read data moved outside a read");
  AST_HOLD_A: assert property ($past(ctrl_r[7:6]) == 2'h0 |-> $stable(wave_out_a_out))
    else $error("wave a moved with no action");
  AST_HALT: assert property (s_halt |-> $stable(wave_out_a_out) && $stable(wave_out_b_out))
    else $error("wave moved while stopped");
  AST_B_NOTOG: assert property ($past(ctrl_r[0]) && $past(ctrl_r[5:4]) == 2'h1 |-> $stable(wave_out_b_out))
    else $error("wave b toggled in pwm");
endmodule

// >>> tpwm_pin.sv
// Port pin model for one wave output.
// Assumes a pad pull-up while the driver is off.
module tpwm_pin (
  // Pin control
  input wire wave_in,
  input wire dir_in,
  // Pin level
  output wire pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wave visible only with direction set to output
  assign pin_out = dir_in ? wave_in : 1'h1;
endmodule

// >>> testbench.sv
// Self-checking bench for the waveform timer.
// Assumes tpwm_top, its checker and the pin model.
`include "tpwm_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  reg core_clk_in, rstn_in, psel_in, penable_in, pwrite_in, pin_dir, err;
  reg [7:0] paddr_in;
  reg [31:0] pwdata_in, rd;
  wire pready_out, pslverr_out, wave_out_a_out, wave_out_b_out, pin_a, pin_b;
  wire [31:0] prdata_out;
  integer n_mismatch = 0, samples_checked = 0, cyc = 0, hi, lo;
  tpwm_top i_tpwm_top (.core_clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .pready_out, .prdata_out, .pslverr_out, .wave_out_a_out, .wave_out_b_out);
  tpwm_pin i_pin_a (.wave_in(wave_out_a_out), .dir_in(pin_dir), .pin_out(pin_a));
  tpwm_pin i_pin_b (.wave_in(wave_out_b_out), .dir_in(pin_dir), .pin_out(pin_b));
  // Clock and hang guard
  initial begin
    core_clk_in = 1'h0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      n_mismatch = n_mismatch + 1;
      complete_run;
    end
  end
  task complete_run;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until ready
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge core_clk_in);
    psel_in <= 1'h1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'h1;
    @(posedge core_clk_in);
    while (pready_out !== 1'h1) @(posedge core_clk_in);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    apb(1'h1, a, d);
  endtask
  task cfg(input [2:0] m, input [1:0] a, input [1:0] b, input [2:0] p);
    wr(`TPWM_ADDR_CTRL, {21'h0, p, a, b, 1'h0, m});
  endtask
  // Cycles until the chosen pin changes, capped
  task gap(input s, output integer n);
    reg v;
    v = s ? pin_b : pin_a;
    n = 0;
    do begin
      @(negedge core_clk_in);
      n = n + 1;
    end while ((s ? pin_b : pin_a) === v && n < 2100);
  endtask
  // High and low lengths from a rising edge
  task hl(input s);
    repeat (520) @(negedge core_clk_in);
    gap(s, hi);
    if ((s ? pin_b : pin_a) !== 1'h1)
      gap(s, hi);
    gap(s, hi);
    gap(s, lo);
  endtask
  task flat(input s, input v);
    repeat (600) @(negedge core_clk_in);
    gap(s, hi);
    chk(hi, 32'h834);
    chk({31'h0, s ? pin_b : pin_a}, {31'h0, v});
  endtask
  task t_reset;
    apb(1'h0, `TPWM_ADDR_CMPA, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 8'h14, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
  endtask
  task t_miss;
    cfg(`TPWM_MODE_CTC, `TPWM_ACT_TOGGLE, `TPWM_ACT_NONE, `TPWM_PRE_STOP);
    wr(`TPWM_ADDR_COUNT, 32'h20);
    wr(`TPWM_ADDR_CMPA, 32'h4);
    wr(`TPWM_ADDR_STATUS, 32'h7);
    cfg(`TPWM_MODE_CTC, `TPWM_ACT_TOGGLE, `TPWM_ACT_NONE, `TPWM_PRE_1);
    gap(1'h0, hi);
    chk({31'h0, hi > 200}, 32'h1);
    gap(1'h0, hi);
    chk(hi, 32'h5);
    apb(1'h0, `TPWM_ADDR_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h3);
  endtask
  task t_presc;
    integer i;
    wr(`TPWM_ADDR_CMPA, 32'h1);
    for (i = 1; i < 6; i = i + 1) begin
      cfg(`TPWM_MODE_CTC, `TPWM_ACT_TOGGLE, `TPWM_ACT_NONE, i[2:0]);
      gap(1'h0, hi);
      gap(1'h0, hi);
      gap(1'h0, hi);
      chk(hi, 2 * (i < 4 ? 1 << (3 * i - 3) : 1 << (2 * i)));
    end
  endtask
  task t_fast;
    wr(`TPWM_ADDR_CMPA, 32'h40);
    cfg(`TPWM_MODE_FAST_FF, `TPWM_ACT_CLEAR, `TPWM_ACT_NONE, `TPWM_PRE_1);
    wr(`TPWM_ADDR_STATUS, 32'h7);
    hl(1'h0);
    chk(hi, 32'h41);
    chk(lo, 32'hbf);
    apb(1'h0, `TPWM_ADDR_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    cfg(`TPWM_MODE_FAST_FF, `TPWM_ACT_SET, `TPWM_ACT_NONE, `TPWM_PRE_1);
    hl(1'h0);
    chk(hi, 32'hbf);
    wr(`TPWM_ADDR_CMPA, 32'h0);
    cfg(`TPWM_MODE_FAST_FF, `TPWM_ACT_CLEAR, `TPWM_ACT_NONE, `TPWM_PRE_1);
    hl(1'h0);
    chk(hi, 32'h1);
    wr(`TPWM_ADDR_CMPA, 32'hff);
    flat(1'h0, 1'h1);
  endtask
  task t_fast7;
    wr(`TPWM_ADDR_CMPA, 32'h9);
    wr(`TPWM_ADDR_CMPB, 32'h3);
    cfg(`TPWM_MODE_FAST_CMP, `TPWM_ACT_TOGGLE, `TPWM_ACT_CLEAR, `TPWM_PRE_1);
    hl(1'h0);
    chk(hi + lo, 32'h14);
    chk(hi, 32'ha);
    hl(1'h1);
    chk(hi, 32'h4);
    chk(lo, 32'h6);
    cfg(`TPWM_MODE_FAST_FF, `TPWM_ACT_TOGGLE, `TPWM_ACT_TOGGLE, `TPWM_PRE_1);
    flat(1'h0, pin_a);
  endtask
  task t_pc;
    wr(`TPWM_ADDR_CMPA, 32'h80);
    cfg(`TPWM_MODE_PC_FF, `TPWM_ACT_CLEAR, `TPWM_ACT_NONE, `TPWM_PRE_1);
    wr(`TPWM_ADDR_STATUS, 32'h7);
    hl(1'h0);
    chk(hi, 32'h100);
    chk(lo, 32'hfe);
    apb(1'h0, `TPWM_ADDR_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    wr(`TPWM_ADDR_CMPA, 32'h0);
    flat(1'h0, 1'h0);
    wr(`TPWM_ADDR_CMPA, 32'hff);
    flat(1'h0, 1'h1);
    wr(`TPWM_ADDR_CMPA, 32'h8);
    wr(`TPWM_ADDR_CMPB, 32'h3);
    cfg(`TPWM_MODE_PC_CMP, `TPWM_ACT_NONE, `TPWM_ACT_CLEAR, `TPWM_PRE_1);
    hl(1'h1);
    chk(hi, 32'h6);
    chk(lo, 32'ha);
  endtask
  // Reset, then the scenarios in turn
  initial begin
    rstn_in = 1'h0;
    psel_in = 1'h0;
    penable_in = 1'h0;
    pwrite_in = 1'h0;
    paddr_in = 8'h0;
    pwdata_in = 32'h0;
    pin_dir = 1'h0;
    repeat (3) @(posedge core_clk_in);
    rstn_in <= 1'h1;
    pin_dir <= 1'h1;
    t_reset;
    t_miss;
    t_presc;
    t_fast;
    t_fast7;
    t_pc;
    complete_run;
  end
endmodule
bind tpwm_top tpwm_props i_tpwm_props (.core_clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .pready_out, .prdata_out, .pslverr_out, .wave_out_a_out, .wave_out_b_out);
